// [shared/sdct_pkg.sv]
package sdct_pkg;
  localparam int CLK_PERIOD_NS = 10;
  function automatic int ns2cyc(input int ns);
    int r;
    r = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (r < 1) r = 1;
    return r;
  endfunction
  localparam int T_RC_NS = 63;
  localparam int T_RAS_MIN_NS = 42;
  localparam int T_RAS_MAX_NS = 100000;
  localparam int T_RP_NS = 20;
  localparam int T_RCD_NS = 20;
  localparam int T_RRD_NS = 14;
  localparam int T_RC_CYC = ns2cyc(T_RC_NS);
  localparam int T_RAS_CYC = ns2cyc(T_RAS_MIN_NS);
  localparam int T_RASMAX_CYC = T_RAS_MAX_NS / CLK_PERIOD_NS;
  localparam int T_RP_CYC = ns2cyc(T_RP_NS);
  localparam int T_RCD_CYC = ns2cyc(T_RCD_NS);
  localparam int T_RRD_CYC = ns2cyc(T_RRD_NS);
  localparam int T_WR_CYC = 2;
  localparam int T_DAL_CYC = 5;
  localparam int T_MRD_CYC = 2;
  localparam int T_CKA_CYC = 2;
  localparam int T_DQZ_CYC = 2;
  localparam int T_ROH_CL3 = 3;
  localparam int T_ROH_CL2 = 2;
  localparam int T_POWERUP_US = 200;
  localparam int T_POWERUP_CYC = T_POWERUP_US * 1000 / CLK_PERIOD_NS;
  localparam int T_REF_MS = 64;
  localparam int REF_ROWS = 4096;
  localparam int T_REFI_CYC = T_REF_MS * 1000000 / CLK_PERIOD_NS / REF_ROWS;
  localparam int INIT_REFRESHES = 2;
  localparam int BANKS = 4;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  localparam int COL_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int MODE_CL_LSB = 4;
  localparam logic [2:0] CL_TWO = 3'h2;
  localparam logic [2:0] CL_THREE = 3'h3;
  // Command code is {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_STOP = 4'h6;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_INH = 4'hf;
endpackage

// [shared/sdct_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface sdct_if;
  logic [3:0] cmd;
  logic [1:0] bank;
  logic [sdct_pkg::ADDR_W-1:0] addr;
  logic cke;
  logic [1:0] dqm;
  logic [sdct_pkg::DATA_W-1:0] dqCtrlOut;
  logic dqCtrlOe;
  logic [sdct_pkg::DATA_W-1:0] dqMemOut;
  logic dqMemOe;
  wire [sdct_pkg::DATA_W-1:0] dq;
  assign dq = dqCtrlOe ? dqCtrlOut : dqMemOe ? dqMemOut : '0;
  modport mem (input cmd, bank, addr, cke, dqm, dqCtrlOut, dqCtrlOe, dq,
    output dqMemOut, dqMemOe);
  modport ctrl (output cmd, bank, addr, cke, dqm, dqCtrlOut, dqCtrlOe,
    input dqMemOut, dqMemOe, dq);
endinterface
`default_nettype wire

// [verilog/sdct_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module sdct_ctrl #(
  parameter int POWERUP_CYC = sdct_pkg::T_POWERUP_CYC,
  parameter int REFI_CYC = sdct_pkg::T_REFI_CYC,
  parameter int RASMAX_CYC = sdct_pkg::T_RASMAX_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  sdct_if.ctrl mem,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [1:0] reqBank,
  input wire logic [sdct_pkg::ADDR_W-1:0] reqRow,
  input wire logic [sdct_pkg::COL_W-1:0] reqCol,
  input wire logic [sdct_pkg::DATA_W-1:0] reqData,
  input wire logic [1:0] reqMask,
  output logic reqReady,
  output logic rdValid,
  output logic [sdct_pkg::DATA_W-1:0] rdData,
  output logic initDone
);
  typedef enum logic [3:0] {
    ST_POWER, ST_PREALL, ST_INITREF, ST_MRS, ST_IDLE, ST_ACT, ST_RW,
    ST_WAITRD, ST_PRE, ST_REF
  } sdct_state_t;
  typedef struct packed {
    sdct_state_t st;
    logic [31:0] waitCnt;
    logic [31:0] refCnt;
    logic [31:0] rasCnt;
    logic [1:0] refDone;
    logic refPend;
    logic wr;
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [sdct_pkg::ADDR_W-1:0] addr;
    logic [1:0] dqm;
    logic [sdct_pkg::DATA_W-1:0] dout;
    logic doe;
    logic [3:0] rdPipe;
    logic rdValid;
    logic [sdct_pkg::DATA_W-1:0] rdData;
    logic initDone;
    logic [1:0] cb;
    logic [sdct_pkg::ADDR_W-1:0] cr;
    logic [sdct_pkg::COL_W-1:0] cc;
    logic [sdct_pkg::DATA_W-1:0] cd;
    logic [1:0] cm;
  } sdct_ctrl_state_t;
  sdct_ctrl_state_t s_reg, s_next;

  // Minimum intervals use the slower grade, rounded up in the package; the refresh and tRAS maximum round down
  function automatic logic [31:0] cyc(input int n);
    return 32'(n - 1);
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.cmd = sdct_pkg::CMD_NOP;
    s_next.doe = 1'b0;
    s_next.dqm = 2'h0;
    // Read mask goes out two cycles ahead of its word
    if (s_reg.rdPipe[0]) s_next.dqm = s_reg.cm;
    s_next.rdValid = 1'b0;
    s_next.rdPipe = {s_reg.rdPipe[2:0], 1'b0};
    // Word stands in the cycle before the fourth edge after the read
    if (s_reg.rdPipe[3]) begin
      s_next.rdValid = 1'b1;
      s_next.rdData = mem.dq;
    end
    if (s_reg.waitCnt != 32'h0) s_next.waitCnt = s_reg.waitCnt - 32'h1;
    if (s_reg.st == ST_RW || s_reg.st == ST_WAITRD) begin
      s_next.rasCnt = s_reg.rasCnt + 32'h1;
    end
    case (s_reg.st)
      ST_POWER: begin
        s_next.cmd = sdct_pkg::CMD_NOP;
        s_next.dqm = 2'h3;
        if (s_reg.waitCnt == 32'h0) s_next.st = ST_PREALL;
      end
      ST_PREALL: begin
        s_next.cmd = sdct_pkg::CMD_PRE;
        s_next.addr = 12'h400;
        s_next.waitCnt = cyc(sdct_pkg::T_RP_CYC);
        s_next.st = ST_INITREF;
      end
      ST_INITREF: if (s_reg.waitCnt == 32'h0) begin
        if (s_reg.refDone == 2'(sdct_pkg::INIT_REFRESHES)) begin
          s_next.st = ST_MRS;
        end else begin
          s_next.cmd = sdct_pkg::CMD_REF;
          s_next.refDone = s_reg.refDone + 2'h1;
          s_next.waitCnt = cyc(sdct_pkg::T_RC_CYC);
        end
      end
      ST_MRS: if (s_reg.waitCnt == 32'h0) begin
        s_next.cmd = sdct_pkg::CMD_MRS;
        // Burst length one, sequential, read latency three
        // One-word bursts never need a burst stop
        s_next.addr = 12'(sdct_pkg::CL_THREE) << sdct_pkg::MODE_CL_LSB;
        s_next.waitCnt = cyc(sdct_pkg::T_MRD_CYC);
        s_next.st = ST_IDLE;
        s_next.initDone = 1'b1;
      end
      ST_IDLE: if (s_reg.waitCnt == 32'h0) begin
        if (s_reg.refPend) begin
          s_next.cmd = sdct_pkg::CMD_REF;
          s_next.refPend = 1'b0;
          s_next.waitCnt = cyc(sdct_pkg::T_RC_CYC);
        end else if (reqValid) begin
          s_next.cmd = sdct_pkg::CMD_ACT;
          s_next.bank = reqBank;
          s_next.addr = reqRow;
          s_next.cb = reqBank;
          s_next.cr = reqRow;
          s_next.cc = reqCol;
          s_next.cd = reqData;
          s_next.cm = reqMask;
          s_next.wr = reqWrite;
          s_next.rasCnt = 32'h1;
          // One open bank at a time, so tRRD is met by tRC
          s_next.waitCnt = cyc(sdct_pkg::T_RCD_CYC);
          s_next.st = ST_RW;
        end
      end
      ST_RW: if (s_reg.waitCnt == 32'h0) begin
        s_next.cmd = s_reg.wr ? sdct_pkg::CMD_WR : sdct_pkg::CMD_RD;
        s_next.bank = s_reg.cb;
        s_next.addr = {4'h0, s_reg.cc}; // No auto-precharge
        if (s_reg.wr) begin
          s_next.doe = 1'b1;
          s_next.dout = s_reg.cd;
          s_next.dqm = s_reg.cm;
          s_next.waitCnt = cyc(sdct_pkg::T_WR_CYC + 1);
        end else begin
          s_next.rdPipe = {s_reg.rdPipe[2:0], 1'b1};
          s_next.waitCnt = cyc(4);
        end
        s_next.st = ST_WAITRD;
      end
      // Precharge once tRAS is met and the access has finished, or when rasCnt nears the tRAS maximum
      ST_WAITRD: if ((s_reg.waitCnt == 32'h0 ||
          s_reg.rasCnt >= 32'(RASMAX_CYC - 1)) &&
          s_reg.rasCnt >= 32'(sdct_pkg::T_RAS_CYC)) begin
        s_next.cmd = sdct_pkg::CMD_PRE;
        s_next.bank = s_reg.cb;
        s_next.addr = 12'h0;
        s_next.waitCnt = cyc(sdct_pkg::T_RP_CYC);
        s_next.st = ST_IDLE;
      end
      default: s_next.st = ST_POWER;
    endcase
    // After the state logic, so a new refresh request beats a clear
    if (s_reg.initDone) begin
      if (s_reg.refCnt == 32'(REFI_CYC - 1)) begin
        s_next.refCnt = 32'h0;
        s_next.refPend = 1'b1;
      end else begin
        s_next.refCnt = s_reg.refCnt + 32'h1;
      end
    end
    if (!rst_n) begin
      s_next = '0;
      s_next.st = ST_POWER;
      s_next.cmd = sdct_pkg::CMD_NOP;
      s_next.waitCnt = 32'(POWERUP_CYC - 1);
    end
  end

  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
  end

  assign mem.cmd = s_reg.cmd;
  assign mem.bank = s_reg.bank;
  assign mem.addr = s_reg.addr;
  assign mem.cke = 1'b1; // Never suspended, so no recovery wait
  assign mem.dqm = s_reg.dqm;
  assign mem.dqCtrlOut = s_reg.dout;
  assign mem.dqCtrlOe = s_reg.doe;
  assign reqReady = s_reg.st == ST_IDLE && s_reg.waitCnt == 32'h0 &&
    !s_reg.refPend;
  assign rdValid = s_reg.rdValid;
  assign rdData = s_reg.rdData;
  assign initDone = s_reg.initDone;
endmodule // sdct_ctrl
`default_nettype wire

// [verilog/sdct_mem.sv]
`timescale 1ns/1ns
`default_nettype none
module sdct_mem (
  input wire logic sys_clk,
  input wire logic rst_n,
  sdct_if.mem mem,
  output logic suspended,
  output logic [2:0] readLatency
);
  typedef struct packed {
    logic ckeLate;
    logic [2:0] cl;
    logic [2:0] rdPipe;
    logic [2:0] prePipe;
    logic [1:0] mskPipe;
    logic [sdct_pkg::COL_W-1:0] rdCol;
    logic [sdct_pkg::DATA_W-1:0] dout;
    logic doe;
  } sdct_mem_state_t;
  sdct_mem_state_t s_reg, s_next;
  logic [sdct_pkg::DATA_W-1:0] mem_q [sdct_pkg::MEM_DEPTH];
  logic active;
  logic [sdct_pkg::DATA_W-1:0] wmask;

  // Suspension takes hold the cycle after cke is sampled low
  // and lifts the cycle after it returns high
  assign active = s_reg.ckeLate;
  assign wmask = {{8{~mem.dqm[1]}}, {8{~mem.dqm[0]}}};

  always_comb begin
    s_next = s_reg;
    s_next.ckeLate = mem.cke;
    if (active) begin
      s_next.rdPipe = {s_reg.rdPipe[1:0], 1'b0};
      s_next.prePipe = {s_reg.prePipe[1:0], 1'b0};
      s_next.mskPipe = {s_reg.mskPipe[0], |mem.dqm};
      // Column command accepted every cycle
      if (mem.cmd == sdct_pkg::CMD_RD) begin
        s_next.rdPipe[0] = 1'b1;
        s_next.rdCol = mem.addr[sdct_pkg::COL_W-1:0];
      end
      if (mem.cmd == sdct_pkg::CMD_PRE) s_next.prePipe[0] = 1'b1;
      if (mem.cmd == sdct_pkg::CMD_MRS) begin
        s_next.cl = mem.addr[sdct_pkg::MODE_CL_LSB +: 3];
      end
      s_next.doe = 1'b0;
      // Latency counted from the registered read command
      if ((s_reg.cl == sdct_pkg::CL_TWO && s_reg.rdPipe[0]) ||
          (s_reg.cl != sdct_pkg::CL_TWO && s_reg.rdPipe[1])) begin
        s_next.doe = 1'b1;
        s_next.dout = mem_q[s_reg.rdCol];
      end
      // Mask seen two cycles ahead floats the word due now
      if (s_reg.mskPipe[0]) s_next.doe = 1'b0;
      if ((s_reg.cl == sdct_pkg::CL_TWO && s_reg.prePipe[0]) ||
          (s_reg.cl != sdct_pkg::CL_TWO && s_reg.prePipe[1])) begin
        s_next.doe = 1'b0;
      end
    end
    if (!rst_n) begin
      s_next = '0;
      s_next.ckeLate = 1'b1;
      // Latency is unset until the first mode load
    end
  end

  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
    // Mask applies in the cycle of the data, first word with command
    if (active && mem.cmd == sdct_pkg::CMD_WR) begin
      mem_q[mem.addr[sdct_pkg::COL_W-1:0]] <=
        (mem.dq & wmask) | (mem_q[mem.addr[sdct_pkg::COL_W-1:0]] & ~wmask);
    end
  end

  assign mem.dqMemOut = s_reg.dout;
  assign mem.dqMemOe = s_reg.doe;
  assign suspended = !s_reg.ckeLate;
  assign readLatency = s_reg.cl;
endmodule // sdct_mem
`default_nettype wire

// [tb/sdct_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module sdct_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] cmd,
  input wire logic [1:0] dqm,
  input wire logic dqCtrlOe,
  input wire logic dqMemOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence actSeen;
    cmd == sdct_pkg::CMD_ACT;
  endsequence
  sequence rdLaunch;
    cmd == sdct_pkg::CMD_RD ##1 dqm == 2'h0;
  endsequence
  sequence rdReturn;
    !dqMemOe ##1 dqMemOe;
  endsequence
  act_to_col_a: assert property (actSeen |=>
    !(cmd == sdct_pkg::CMD_RD || cmd == sdct_pkg::CMD_WR))
    else $error("column command too soon after activate");
  act_to_pre_a: assert property (actSeen |=>
    (cmd != sdct_pkg::CMD_PRE) [*4])
    else $error("precharge too soon after activate");
  act_to_act_a: assert property (actSeen |=>
    cmd != sdct_pkg::CMD_ACT)
    else $error("activates too close");
  pre_to_act_a: assert property (cmd == sdct_pkg::CMD_PRE |=>
    cmd != sdct_pkg::CMD_ACT)
    else $error("activate too soon after precharge");
  ref_spacing_a: assert property (cmd == sdct_pkg::CMD_REF |=>
    (cmd != sdct_pkg::CMD_REF && cmd != sdct_pkg::CMD_ACT) [*6])
    else $error("refresh period too short");
  wr_data_a: assert property (cmd == sdct_pkg::CMD_WR |->
    dqCtrlOe)
    else $error("write data not with command");
  wr_recovery_a: assert property (cmd == sdct_pkg::CMD_WR |=>
    cmd != sdct_pkg::CMD_PRE)
    else $error("precharge too soon after write");
  mode_wait_a: assert property (cmd == sdct_pkg::CMD_MRS |=>
    !(cmd == sdct_pkg::CMD_ACT || cmd == sdct_pkg::CMD_REF))
    else $error("command too soon after mode load");
  rd_latency_a: assert property (rdLaunch |=> rdReturn)
    else $error("read data not at latency three");
  mask_float_a: assert property (dqm != 2'h0 |-> ##2 !dqMemOe)
    else $error("masked read word still driven");
  act_rc_a: assert property (actSeen |=>
    (cmd != sdct_pkg::CMD_ACT && cmd != sdct_pkg::CMD_REF) [*6])
    else $error("activate period too short");
  bus_clash_a: assert property (!(dqMemOe && dqCtrlOe))
    else $error("both ends drive data");
endmodule // sdct_sva
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [1:0] reqBank = '0;
  logic [sdct_pkg::ADDR_W-1:0] reqRow = '0;
  logic [sdct_pkg::COL_W-1:0] reqCol = '0;
  logic [sdct_pkg::DATA_W-1:0] reqData = '0;
  logic [1:0] reqMask = '0;
  logic reqReady, rdValid, initDone, suspended;
  logic [sdct_pkg::DATA_W-1:0] rdData;
  logic [2:0] readLatency;
  int nFail = 0;
  int nCompared = 0;
  int cyc = 0;
  sdct_if bus ();
  // Short power-up and refresh interval keep the run brief
  sdct_ctrl #(.POWERUP_CYC(10), .REFI_CYC(50), .RASMAX_CYC(1000)) u_sdct_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .mem(bus), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqBank(reqBank), .reqRow(reqRow),
    .reqCol(reqCol), .reqData(reqData), .reqMask(reqMask),
    .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
    .initDone(initDone));
  sdct_mem u_sdct_mem (.sys_clk(sys_clk), .rst_n(rst_n), .mem(bus),
    .suspended(suspended), .readLatency(readLatency));
  sdct_sva u_sdct_sva (.sys_clk(sys_clk), .rst_n(rst_n), .cmd(bus.cmd),
    .dqm(bus.dqm), .dqCtrlOe(bus.dqCtrlOe), .dqMemOe(bus.dqMemOe));
  always #5 sys_clk = ~sys_clk;
  task automatic complete_run();
    if (nFail == 0 && nCompared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      nFail++;
      complete_run();
    end
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic access(logic w, logic [1:0] b, logic [7:0] c,
      logic [15:0] d, logic [1:0] m);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqBank <= b;
    reqRow <= {4'h0, c};
    reqCol <= c;
    reqData <= d;
    reqMask <= m;
    forever begin
      @(posedge sys_clk);
      if (reqReady === 1'b1) break;
    end
    reqValid <= 1'b0;
  endtask
  task automatic rd(logic [1:0] b, logic [7:0] c, logic [1:0] m,
      logic [15:0] exp);
    access(1'b0, b, c, 16'h0000, m);
    for (int k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (rdValid === 1'b1) break;
    end
    check("rdValid", {15'h0, rdValid}, 16'h0001);
    check("rdData", rdData, exp);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    while (initDone !== 1'b1) @(posedge sys_clk);
    // The memory takes the mode one edge after the controller flags done
    @(posedge sys_clk);
    check("readLatency", {13'h0000, readLatency}, 16'h0003);
    check("suspended", {15'h0, suspended}, 16'h0000);
    for (int b = 0; b < 4; b++) begin
      access(1'b1, b[1:0], 8'h10 + 8'(b), 16'ha5c0 + 16'(b), 2'h0);
    end
    for (int b = 0; b < 4; b++) begin
      rd(b[1:0], 8'h10 + 8'(b), 2'h0, 16'ha5c0 + 16'(b));
    end
    // Each byte masked in turn: only the other byte may change
    access(1'b1, 2'h1, 8'h11, 16'h3c7e, 2'h1);
    rd(2'h1, 8'h11, 2'h0, 16'h3cc1);
    access(1'b1, 2'h2, 8'h12, 16'h3c7e, 2'h2);
    rd(2'h2, 8'h12, 2'h0, 16'ha57e);
    // Idle long enough for several refreshes, then the data must remain
    repeat (200) @(posedge sys_clk);
    rd(2'h3, 8'h13, 2'h0, 16'ha5c3);
    rd(2'h0, 8'h10, 2'h0, 16'ha5c0);
    // A fully masked read leaves the bus undriven, which resolves to zero
    rd(2'h3, 8'h13, 2'h3, 16'h0000);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
